// ---- src/dakc_cmd.sv ----
// Digest and key generation command engine with AXI4-Lite register access
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module dakc_cmd (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output dakc_pkg::dakc_sha_out_t sha_out,
	input wire dakc_pkg::dakc_sha_in_t sha_in,
	output dakc_pkg::dakc_ecc_out_t ecc_out,
	input wire dakc_pkg::dakc_ecc_in_t ecc_in,
	output logic seed_req,
	input wire logic seed_ack
);
	import dakc_pkg::*;

	typedef struct packed {
		dakc_state_t st;
		logic aw_ok;
		logic w_ok;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] param;
		logic [31:0] setup;
		logic [31:0] flags;
		logic [23:0] serial;
		logic [31:0] counter;
		logic [255:0] extra;
		logic [255:0] stored;
		logic [255:0] scratch;
		logic [511:0] pubkey;
		logic scr_valid;
		logic scr_rng;
		logic seed_done;
		logic keygen;
		logic [7:0] code;
		logic resp_key;
		logic [1023:0] msg;
		logic [7:0] left;
		logic sha_valid;
		logic ecc_req;
		dakc_ecc_op_t ecc_op;
		logic seed_req;
	} dakc_regs_t;

	dakc_regs_t s;
	dakc_regs_t next_s;

	// Byte-enable merge, shared by every writable word except the control and scratch control words
	function automatic logic [31:0] dakc_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : dakc_merge

	// Word k of a 32-byte block, byte 0 in the top lane
	function automatic logic [31:0] dakc_word(input logic [255:0] v, input logic [2:0] k);
		return v[(3'd7 - k)*32 +: 32];
	endfunction : dakc_word

	// Fields of the command and of the selected slot
	logic [7:0] p1;
	logic [15:0] kid;
	logic [7:0] sn8;
	logic [15:0] sn01;
	logic cfg_locked;
	logic data_locked;
	logic auth_bad;
	logic needs_rng;
	assign p1 = s.param[7:0];
	assign kid = s.param[31:16];
	assign sn8 = s.serial[7:0];
	assign sn01 = {s.serial[15:8], s.serial[23:16]}; // Serial byte 0 goes first
	assign cfg_locked = s.flags[FL_CFG_LOCKED];
	assign data_locked = s.flags[FL_DATA_LOCKED];
	assign needs_rng = s.setup[16 + KS_RNG] && !s.scr_rng;
	// Authorizing slot must match the one named by the key setup word
	assign auth_bad = s.setup[16 + KS_REQ_AUTH] &&
		!(s.flags[FL_AUTH_DONE] && s.flags[FL_AUTH_SLOT +: 4] == s.setup[16 + KS_AUTH_SLOT +: 4]);

	// Digest message pieces: head, middle 32 bytes, tail
	logic [255:0] dg_head;
	logic [255:0] dg_mid;
	logic [255:0] dg_tail;
	logic [255:0] kg_mid;
	logic [7:0] lock_byte;
	always_comb begin
		lock_byte = {7'h00, s.flags[FL_SLOT_LOCK]};
		dg_head = s.stored;
		dg_tail = s.scratch;
		dg_mid = {OPC_DIGEST, p1, kid, sn8, sn01, 200'h0};
		if (p1 == ZONE_SHARED) begin
			dg_mid = {OPC_DIGEST, p1, kid[7:0], 8'h00, sn8, sn01, 200'h0};
			dg_head = kid[15] ? s.scratch : s.extra;
			dg_tail = kid[15] ? s.extra : s.scratch;
		end else if (p1 == ZONE_DATA && s.setup[SS_HOST_ROLE]) begin
			dg_mid = {s.extra[255:224], sn8, sn01, 200'h0};
		end else if (p1 == ZONE_COUNTER) begin
			dg_head = 256'h0;
			dg_mid = {OPC_DIGEST, p1, kid, sn8, sn01, 8'h00, s.counter, 160'h0};
		end else if (p1 == ZONE_KEYCFG) begin
			dg_head = 256'h0;
			dg_mid = {OPC_DIGEST, p1, kid, sn8, sn01, 8'h00, s.setup[15:0], s.setup[31:16], lock_byte, 152'h0};
		end
		// Stored public key replaces the parameter bytes with extra input
		if (p1[M_STOREDPUB]) begin
			kg_mid = {OPC_KEYGEN, s.extra[255:232], sn8, sn01, 200'h0};
		end else begin
			kg_mid = {OPC_KEYGEN, p1, kid, sn8, sn01, 200'h0};
		end
	end

	// Check results, evaluated in the check state
	logic dg_err;
	logic kg_err;
	always_comb begin
		dg_err = !s.scr_valid;
		if (p1 > ZONE_KEYCFG) begin
			dg_err = 1'b1;
		end
		if (p1 == ZONE_CONFIG && kid > KID_CFG_MAX) begin
			dg_err = 1'b1;
		end
		// Mask keys only usable with an RNG-made nonce
		if (p1 == ZONE_DATA && (kid[15] ? !s.scr_rng : (data_locked && needs_rng))) begin
			dg_err = 1'b1;
		end
		kg_err = !cfg_locked || p1[7:5] != 3'h0 || p1[1:0] != 2'h0;
		if (p1[M_STOREDPUB]) begin
			// Only scratch, auth and limited-use checks on a stored key
			kg_err = kg_err || !s.scr_valid || needs_rng || !s.flags[FL_LIMIT_OK] ||
				(data_locked && auth_bad);
		end else begin
			kg_err = kg_err || !s.setup[16 + KS_PRIVATE] || !s.setup[SS_SECRET];
			kg_err = kg_err || s.setup[16 + KS_CURVE +: 3] != CURVE_OK;
			if (p1[M_PUBDIGEST]) begin
				kg_err = kg_err || !s.scr_valid || needs_rng;
			end
			if (p1[M_KEYCREATE]) begin
				kg_err = kg_err || !s.flags[FL_SLOT_LOCK];
				kg_err = kg_err || (data_locked && (!s.setup[SS_GEN_ALLOW] || auth_bad));
			end else begin
				kg_err = kg_err || (data_locked && (!s.setup[16 + KS_PUBLIC_INFO_FLAG] || auth_bad));
			end
		end
	end

	// Single next-state process: bus slave plus command sequencer
	logic wr_go;
	logic [7:0] ra;
	always_comb begin
		next_s = s;
		wr_go = 1'b0;
		ra = 8'h00;
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.aw_ok = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.w_ok = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		// Write commits once both halves are held
		if (s.aw_ok && s.w_ok && !s.bvalid) begin
			wr_go = 1'b1;
			next_s.aw_ok = 1'b0;
			next_s.w_ok = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			if (s.awaddr[7:5] == OFS_EXTRA[7:5]) begin
				next_s.extra[(3'd7 - s.awaddr[4:2])*32 +: 32] =
					dakc_merge(dakc_word(s.extra, s.awaddr[4:2]), s.wdata, s.wstrb);
			end else if (s.awaddr[7:5] == OFS_STORED[7:5]) begin
				next_s.stored[(3'd7 - s.awaddr[4:2])*32 +: 32] =
					dakc_merge(dakc_word(s.stored, s.awaddr[4:2]), s.wdata, s.wstrb);
			end else if (s.awaddr[7:5] == OFS_SCRATCH[7:5] && s.st == ST_IDLE) begin
				next_s.scratch[(3'd7 - s.awaddr[4:2])*32 +: 32] =
					dakc_merge(dakc_word(s.scratch, s.awaddr[4:2]), s.wdata, s.wstrb);
			end else begin
				case (s.awaddr)
					OFS_CTRL: begin
						// Start ignored while a command runs
						if (s.wstrb[0] && s.wdata[CTRL_START] && s.st == ST_IDLE) begin
							next_s.keygen = s.wdata[CTRL_KEYGEN];
							next_s.st = ST_CHECK;
						end
					end
					OFS_PARAM: next_s.param = dakc_merge(s.param, s.wdata, s.wstrb);
					OFS_SETUP: next_s.setup = dakc_merge(s.setup, s.wdata, s.wstrb);
					OFS_FLAGS: next_s.flags = dakc_merge(s.flags, s.wdata, s.wstrb);
					OFS_SERIAL: next_s.serial = 24'(dakc_merge({8'h00, s.serial}, s.wdata, s.wstrb));
					OFS_COUNTER: next_s.counter = dakc_merge(s.counter, s.wdata, s.wstrb);
					OFS_SCR_CTL: begin
						if (s.wstrb[0] && s.st == ST_IDLE) begin
							next_s.scr_valid = s.wdata[0];
							next_s.scr_rng = s.wdata[1];
						end
					end
					OFS_STATUS: next_s.bresp = RESP_OKAY;
					default: next_s.bresp = RESP_DECERR;
				endcase
			end
		end
		// Reads answer one cycle after the address is taken
		if (s_axi_rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			ra = s_axi_araddr;
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			next_s.rdata = 32'h0;
			if (ra[7:5] == OFS_EXTRA[7:5]) begin
				next_s.rdata = dakc_word(s.extra, ra[4:2]);
			end else if (ra[7:5] == OFS_STORED[7:5]) begin
				next_s.rdata = dakc_word(s.stored, ra[4:2]);
			end else if (ra[7:5] == OFS_SCRATCH[7:5]) begin
				next_s.rdata = 32'h0; // Digest is write-only from the bus
			end else if (ra[7:6] == OFS_PUBKEY[7:6]) begin
				next_s.rdata = s.pubkey[(4'd15 - ra[5:2])*32 +: 32];
			end else begin
				case (ra)
					OFS_CTRL: next_s.rdata = {31'h0, s.keygen} << CTRL_KEYGEN;
					OFS_PARAM: next_s.rdata = s.param;
					OFS_SETUP: next_s.rdata = s.setup;
					OFS_FLAGS: next_s.rdata = s.flags;
					OFS_SERIAL: next_s.rdata = {8'h00, s.serial};
					OFS_COUNTER: next_s.rdata = s.counter;
					OFS_STATUS: next_s.rdata = {16'h0, s.code, 3'h0, s.seed_done, s.resp_key,
						s.scr_rng, s.scr_valid, s.st != ST_IDLE};
					OFS_SCR_CTL: next_s.rdata = {30'h0, s.scr_rng, s.scr_valid};
					default: begin
						next_s.rresp = RESP_DECERR;
					end
				endcase
			end
		end
		// Command sequencer
		case (s.st)
			ST_IDLE: begin
				next_s.sha_valid = 1'b0;
			end
			ST_CHECK: begin
				next_s.resp_key = 1'b0;
				if (s.keygen ? kg_err : dg_err) begin
					next_s.code = CODE_EXEC;
					next_s.st = ST_IDLE;
				end else if (!s.keygen) begin
					next_s.msg = {dg_head, dg_mid, dg_tail, 256'h0};
					next_s.left = LEN_DIGEST;
					next_s.sha_valid = 1'b1;
					next_s.st = ST_HASH;
				end else begin
					// Bit4 overrides bits 2 and 3
					if (p1[M_STOREDPUB]) begin
						next_s.ecc_op = ECC_FETCH;
					end else if (p1[M_KEYCREATE]) begin
						next_s.ecc_op = ECC_CREATE;
					end else begin
						next_s.ecc_op = ECC_COMPUTE;
					end
					if (p1[M_KEYCREATE] && !p1[M_STOREDPUB] && !s.seed_done) begin
						next_s.seed_req = 1'b1;
						next_s.st = ST_SEED;
					end else begin
						next_s.ecc_req = 1'b1;
						next_s.st = ST_ECC;
					end
				end
			end
			ST_SEED: begin
				if (seed_ack) begin
					next_s.seed_req = 1'b0;
					next_s.seed_done = 1'b1;
					next_s.ecc_req = 1'b1;
					next_s.st = ST_ECC;
				end
			end
			ST_ECC: begin
				if (ecc_in.done) begin
					next_s.ecc_req = 1'b0;
					if (ecc_in.fault && s.ecc_op == ECC_CREATE) begin
						next_s.code = CODE_ECC;
						next_s.st = ST_IDLE;
					end else begin
						next_s.pubkey = ecc_in.pubkey;
						next_s.resp_key = !p1[M_STOREDPUB];
						if (p1[M_STOREDPUB] || p1[M_PUBDIGEST]) begin
							next_s.msg = {s.scratch, kg_mid, ecc_in.pubkey};
							next_s.left = LEN_KEYGEN;
							next_s.sha_valid = 1'b1;
							next_s.st = ST_HASH;
						end else begin
							next_s.code = CODE_OK;
							next_s.st = ST_IDLE;
						end
					end
				end
			end
			ST_HASH: begin
				// Engine back-pressure holds the current byte
				if (sha_in.ready) begin
					next_s.msg = {s.msg[1015:0], 8'h00};
					next_s.left = s.left - 8'h01;
					if (s.left == 8'h01) begin
						next_s.sha_valid = 1'b0;
						next_s.st = ST_WAITD;
					end
				end
			end
			ST_WAITD: begin
				if (sha_in.done) begin
					next_s.scratch = sha_in.digest;
					next_s.scr_valid = 1'b1;
					next_s.code = CODE_OK;
					next_s.st = ST_IDLE;
				end
			end
			default: next_s.st = ST_IDLE;
		endcase
		if (!wr_go) begin
			next_s.bresp = s.bvalid ? s.bresp : RESP_OKAY;
		end
	end

	// State register, synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.ecc_op <= ECC_CREATE;
		end else begin
			s <= next_s;
		end
	end

	// Bus handshakes: one transfer per channel in flight
	assign s_axi_awready = !s.aw_ok && !s.bvalid;
	assign s_axi_wready = !s.w_ok && !s.bvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;

	// Engine side outputs
	assign sha_out.valid = s.sha_valid;
	assign sha_out.last = s.sha_valid && s.left == 8'h01;
	assign sha_out.data = s.msg[1023:1016];
	assign ecc_out.req = s.ecc_req;
	assign ecc_out.op = s.ecc_op;
	assign ecc_out.slot = kid[3:0];
	assign seed_req = s.seed_req;
endmodule : dakc_cmd

// ---- src/dakc_pkg.sv ----
// Shared constants, types and carriers for the digest and key generation command block
package dakc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PARAM = 8'h04;
	localparam logic [7:0] OFS_SETUP = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_SERIAL = 8'h10;
	localparam logic [7:0] OFS_COUNTER = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_SCR_CTL = 8'h1C;
	localparam logic [7:0] OFS_EXTRA = 8'h20;
	localparam logic [7:0] OFS_STORED = 8'h40;
	localparam logic [7:0] OFS_SCRATCH = 8'h60;
	localparam logic [7:0] OFS_PUBKEY = 8'h80;
	// Field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_KEYGEN = 1;
	localparam int FL_CFG_LOCKED = 0;
	localparam int FL_DATA_LOCKED = 1;
	localparam int FL_SLOT_LOCK = 2;
	localparam int FL_AUTH_DONE = 3;
	localparam int FL_LIMIT_OK = 4;
	localparam int FL_AUTH_SLOT = 8;
	localparam int SS_HOST_ROLE = 6;
	localparam int SS_SECRET = 7;
	localparam int SS_GEN_ALLOW = 13;
	localparam int KS_PRIVATE = 0;
	localparam int KS_PUBLIC_INFO_FLAG = 1;
	localparam int KS_CURVE = 2;
	localparam int KS_RNG = 6;
	localparam int KS_REQ_AUTH = 7;
	localparam int KS_AUTH_SLOT = 8;
	localparam int M_KEYCREATE = 2;
	localparam int M_PUBDIGEST = 3;
	localparam int M_STOREDPUB = 4;
	// Codes and encodings
	localparam logic [7:0] OPC_DIGEST = 8'h15;
	localparam logic [7:0] OPC_KEYGEN = 8'h40;
	localparam logic [7:0] ZONE_CONFIG = 8'h00;
	localparam logic [7:0] ZONE_DATA = 8'h02;
	localparam logic [7:0] ZONE_SHARED = 8'h03;
	localparam logic [7:0] ZONE_COUNTER = 8'h04;
	localparam logic [7:0] ZONE_KEYCFG = 8'h05;
	localparam logic [15:0] KID_CFG_MAX = 16'h0003;
	localparam logic [2:0] CURVE_OK = 3'h4;
	localparam logic [7:0] CODE_OK = 8'h00;
	localparam logic [7:0] CODE_EXEC = 8'h0F;
	localparam logic [7:0] CODE_ECC = 8'h05;
	localparam logic [7:0] LEN_DIGEST = 8'h60;
	localparam logic [7:0] LEN_KEYGEN = 8'h80;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [1:0] {ECC_CREATE, ECC_COMPUTE, ECC_FETCH} dakc_ecc_op_t;
	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_SEED, ST_ECC, ST_HASH, ST_WAITD} dakc_state_t;
	// Carriers to and from the hash and curve engines
	typedef struct packed {logic valid; logic last; logic [7:0] data;} dakc_sha_out_t;
	typedef struct packed {logic ready; logic done; logic [255:0] digest;} dakc_sha_in_t;
	typedef struct packed {logic req; dakc_ecc_op_t op; logic [3:0] slot;} dakc_ecc_out_t;
	typedef struct packed {logic done; logic fault; logic [511:0] pubkey;} dakc_ecc_in_t;
endpackage : dakc_pkg

// ---- verification/dakc_cmd_assertions.sv ----
// Bus, hash stream and engine request checks bound to the command block
`timescale 1ns/1ps
module dakc_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire dakc_pkg::dakc_sha_out_t sha_out,
	input wire dakc_pkg::dakc_sha_in_t sha_in,
	input wire dakc_pkg::dakc_ecc_out_t ecc_out,
	input wire dakc_pkg::dakc_ecc_in_t ecc_in,
	input wire logic seed_req,
	input wire logic seed_ack
);
	import dakc_pkg::*;
	logic [7:0] taken;
	logic seed_seen;
	// Bytes taken so far in this message, and whether the seed was refreshed
	always_ff @(posedge aclk) begin
		if (!aresetn || (sha_out.valid && sha_in.ready && sha_out.last))
			taken <= 8'h00;
		else if (sha_out.valid && sha_in.ready)
			taken <= taken + 8'h01;
		if (!aresetn)
			seed_seen <= 1'b0;
		else if (seed_req && seed_ack)
			seed_seen <= 1'b1;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response withdrawn early");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data withdrawn early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered in the next cycle");
	a_byte_hold: assert property (sha_out.valid && !sha_in.ready |=> sha_out.valid && $stable(sha_out.data))
		else $error("hash byte changed while stalled");
	a_last_valid: assert property (sha_out.last |-> sha_out.valid)
		else $error("last marker without a byte");
	a_msg_length: assert property (sha_out.valid && sha_in.ready && sha_out.last |->
		taken == LEN_DIGEST - 8'h01 || taken == LEN_KEYGEN - 8'h01)
		else $error("hash message has a wrong length");
	a_ecc_hold: assert property (ecc_out.req && !ecc_in.done |=> ecc_out.req && $stable(ecc_out.op))
		else $error("curve request changed before done");
	a_ecc_release: assert property (ecc_out.req && ecc_in.done |=> !ecc_out.req)
		else $error("curve request held after done");
	a_seed_first: assert property (seed_req |-> !ecc_out.req)
		else $error("curve engine started before seed update");
	a_seed_once: assert property (seed_seen |-> !seed_req)
		else $error("seed refreshed twice in one power cycle");
endmodule : dakc_chk
bind dakc_cmd dakc_chk chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .sha_out(sha_out), .sha_in(sha_in), .ecc_out(ecc_out),
	.ecc_in(ecc_in), .seed_req(seed_req), .seed_ack(seed_ack));

// ---- verification/dakc_cmd_bench.sv ----
// Self-checking bench for the digest and key generation command block
`timescale 1ns/1ps
module dakc_cmd_bench;
	import dakc_pkg::*;
	localparam logic [511:0] PUB = {8{64'h0123_4567_89AB_CDEF}};
	localparam logic [31:0] CNT = 32'h1234_5678;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic seed_req, seed_ack, fault_now, clr;
	logic [7:0] awaddr, araddr, n_bytes;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb, seeds;
	logic [1:0] bresp, rresp, r;
	logic [7:0] msg [0:127];
	logic [7:0] ex [0:127];
	dakc_sha_out_t sha_out;
	dakc_sha_in_t sha_in;
	dakc_ecc_out_t ecc_out;
	dakc_ecc_in_t ecc_in;
	dakc_ecc_op_t last_op;
	int miscompares, tests_run;
	// Clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	dakc_cmd dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sha_out(sha_out),
		.sha_in(sha_in), .ecc_out(ecc_out), .ecc_in(ecc_in), .seed_req(seed_req), .seed_ack(seed_ack));
	dakc_engines #(.PUB(PUB)) eng_u (.aclk(aclk), .aresetn(aresetn), .sha_out(sha_out), .sha_in(sha_in),
		.ecc_out(ecc_out), .ecc_in(ecc_in), .seed_req(seed_req), .seed_ack(seed_ack), .fault_now(fault_now),
		.clr(clr), .msg(msg), .n_bytes(n_bytes), .seeds(seeds), .last_op(last_op));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	// Bus write: both channels offered together, sampled mid-cycle to avoid edge races
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w, b;
		b = 1'b0;
		@(posedge aclk);
		{awaddr, wdata} <= {a, v};
		{awvalid, wvalid, bready} <= 3'h7;
		for (int t = 0; t < 50 && !b; t++) begin
			@(negedge aclk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid && bready;
			if (b)
				cmp(bresp, RESP_OKAY);
			@(posedge aclk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		cmp(b, 1'b1);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] rs);
		logic ar, h;
		h = 1'b0;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (int t = 0; t < 50 && !h; t++) begin
			@(negedge aclk);
			ar = arvalid && arready;
			h = rvalid && rready;
			{q, rs} = {rdata, rresp};
			@(posedge aclk);
			if (ar)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		cmp(h, 1'b1);
	endtask : rd
	task automatic blk(input logic [7:0] base, input logic [7:0] b0);
		for (int i = 0; i < 32; i += 4)
			wr(base + 8'(i), {b0 + 8'(i), b0 + 8'(i + 1), b0 + 8'(i + 2), b0 + 8'(i + 3)});
	endtask : blk
	// Clears the capture, starts a command and polls until no longer busy
	task automatic run(input logic [31:0] c, output logic [31:0] st);
		@(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		wr(OFS_CTRL, c);
		st = 32'h1;
		for (int t = 0; t < 200 && st[0] !== 1'b0; t++)
			rd(OFS_STATUS, st, r);
		cmp(st[0], 1'b0);
	endtask : run
	// Expected hash message; scratch bytes A0.., extra 40.., stored 10..
	task automatic build(input logic [7:0] z, input logic [7:0] m, input logic [15:0] k, input logic [31:0] su);
		logic [7:0] sc, ot;
		logic sw, kd;
		logic [31:0] w;
		sw = (z == ZONE_SHARED) && k[15];
		kd = m[4:3] != 2'h0;
		w = z == ZONE_COUNTER ? CNT : {su[15:0], su[31:16]};
		for (int i = 0; i < 128; i++)
			ex[i] = 8'h00;
		for (int i = 0; i < 32; i++) begin
			sc = 8'hA0 + 8'(i);
			ot = z == ZONE_SHARED ? 8'h40 + 8'(i) : (z == ZONE_COUNTER || z == ZONE_KEYCFG) ? 8'h00 : 8'h10 + 8'(i);
			ex[i] = (sw || kd) ? sc : ot;
			ex[64 + i] = kd ? PUB[511 - 8 * i -: 8] : sw ? ot : sc;
			ex[96 + i] = kd ? PUB[255 - 8 * i -: 8] : 8'h00;
		end
		{ex[32], ex[33]} = {kd ? OPC_KEYGEN : OPC_DIGEST, m};
		{ex[34], ex[35]} = z == ZONE_SHARED ? {k[7:0], 8'h00} : k;
		// Stored public key: extra input replaces the parameter bytes
		if (m[4])
			{ex[33], ex[34], ex[35]} = 24'h40_4142;
		{ex[36], ex[37], ex[38]} = {8'h5A, 8'h01, 8'h23};
		for (int i = 0; i < 4; i++) begin
			if (z == ZONE_DATA && su[SS_HOST_ROLE])
				ex[32 + i] = 8'h40 + 8'(i);
			if (z == ZONE_COUNTER || z == ZONE_KEYCFG)
				ex[40 + i] = w[31 - 8 * i -: 8];
		end
		ex[44] = z == ZONE_KEYCFG ? 8'h01 : 8'h00;
	endtask : build
	task automatic dig(input logic [7:0] z, input logic [15:0] k, input logic [31:0] su, input logic v);
		logic [31:0] st;
		wr(OFS_PARAM, {k, 8'h00, z});
		wr(OFS_SETUP, su);
		wr(OFS_SCR_CTL, {31'h0, v});
		blk(OFS_SCRATCH, 8'hA0);
		run(32'h1, st);
		cmp(st[15:8], v ? CODE_OK : CODE_EXEC);
		cmp(st[1], v);
		cmp(n_bytes, v ? LEN_DIGEST : 8'h00);
		build(z, z, k, su);
		for (int i = 0; i < 96 && v; i++)
			cmp(msg[i], ex[i]);
		$display("test done: digest zone %h valid %b", z, v);
	endtask : dig
	task automatic gen(input logic [7:0] m, input logic [4:0] fl, input logic [31:0] su, input logic [1:0] sc,
		input logic [7:0] code);
		logic [31:0] st;
		logic ok;
		ok = code == CODE_OK;
		wr(OFS_PARAM, {16'h0002, 8'h00, m});
		wr(OFS_SETUP, su);
		wr(OFS_FLAGS, {27'h0, fl});
		wr(OFS_SCR_CTL, {30'h0, sc});
		blk(OFS_SCRATCH, 8'hA0);
		run(32'h3, st);
		cmp(st[15:8], code);
		cmp(n_bytes, ok && m[4:3] != 2'h0 ? LEN_KEYGEN : 8'h00);
		if (!ok || m[4:3] != 2'h0)
			cmp(st[1], ok ? 1'b1 : sc[0]);
		if (ok && !m[4]) begin
			cmp(st[3], 1'b1);
			rd(OFS_PUBKEY, d, r);
			cmp(d, PUB[511:480]);
		end
		build(8'hFF, m, 16'h0002, su);
		for (int i = 0; i < 128 && ok && m[4:3] != 2'h0; i++)
			cmp(msg[i], ex[i]);
		$display("test done: key mode %h code %h", m, code);
	endtask : gen
	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, fault_now, clr} = 8'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		miscompares = 0;
		tests_run = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_STATUS, d, r);
		cmp(d, 32'h0);
		rd(8'hF0, d, r);
		cmp(r, RESP_DECERR);
		$display("test done: reset and unmapped read");
		blk(OFS_EXTRA, 8'h40);
		blk(OFS_STORED, 8'h10);
		wr(OFS_SERIAL, 32'h0023_015A);
		wr(OFS_COUNTER, CNT);
		wr(OFS_FLAGS, 32'h0000_0015);
		dig(ZONE_SHARED, 16'h0001, 32'h0, 1'b0);
		dig(ZONE_SHARED, 16'h0001, 32'h0, 1'b1);
		dig(ZONE_SHARED, 16'h8001, 32'h0, 1'b1);
		dig(ZONE_DATA, 16'h0002, 32'h0000_0040, 1'b1);
		dig(ZONE_COUNTER, 16'h0001, 32'h0, 1'b1);
		dig(ZONE_KEYCFG, 16'h0003, 32'hC3B2_2001, 1'b1);
		dig(ZONE_CONFIG, 16'h0002, 32'h0, 1'b1);
		gen(8'h04, 5'h14, 32'h0013_2080, 2'h1, CODE_EXEC);
		gen(8'h04, 5'h11, 32'h0013_2080, 2'h1, CODE_EXEC);
		gen(8'h04, 5'h15, 32'h0013_2080, 2'h1, CODE_OK);
		gen(8'h04, 5'h15, 32'h0013_2080, 2'h1, CODE_OK);
		cmp(seeds, 4'h1);
		cmp(last_op, ECC_CREATE);
		gen(8'h00, 5'h15, 32'h0013_2000, 2'h1, CODE_EXEC);
		gen(8'h00, 5'h15, 32'h000F_2080, 2'h1, CODE_EXEC);
		gen(8'h04, 5'h17, 32'h0013_0080, 2'h1, CODE_EXEC);
		gen(8'h04, 5'h17, 32'h0093_2080, 2'h1, CODE_EXEC);
		gen(8'h04, 5'h1F, 32'h0093_2080, 2'h1, CODE_OK);
		gen(8'h00, 5'h17, 32'h0011_2080, 2'h1, CODE_EXEC);
		gen(8'h00, 5'h17, 32'h0013_2080, 2'h1, CODE_OK);
		gen(8'h08, 5'h17, 32'h0013_2080, 2'h1, CODE_OK);
		cmp(last_op, ECC_COMPUTE);
		fault_now <= 1'b1;
		gen(8'h04, 5'h15, 32'h0013_2080, 2'h1, CODE_ECC);
		fault_now <= 1'b0;
		gen(8'h04, 5'h15, 32'h0013_2080, 2'h1, CODE_OK);
		gen(8'h1C, 5'h17, 32'h0, 2'h0, CODE_EXEC);
		gen(8'h1C, 5'h17, 32'h0040_0000, 2'h1, CODE_EXEC);
		gen(8'h1C, 5'h17, 32'h0040_0000, 2'h3, CODE_OK);
		cmp(last_op, ECC_FETCH);
		final_report();
	end
	// Watchdog well beyond the expected run of some three thousand cycles
	initial begin
		#500000;
		miscompares++;
		$display("unexpected at %0t: watchdog expired", $time);
		final_report();
	end
endmodule : dakc_cmd_bench

// ---- verification/dakc_engines.sv ----
// Behavioural hash, curve and seed engines on the far side of the block
`timescale 1ns/1ps
module dakc_engines #(
	parameter logic [511:0] PUB = {8{64'h0123_4567_89AB_CDEF}}
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire dakc_pkg::dakc_sha_out_t sha_out,
	output dakc_pkg::dakc_sha_in_t sha_in,
	input wire dakc_pkg::dakc_ecc_out_t ecc_out,
	output dakc_pkg::dakc_ecc_in_t ecc_in,
	input wire logic seed_req,
	output logic seed_ack,
	input wire logic fault_now,
	input wire logic clr,
	output logic [7:0] msg [0:127],
	output logic [7:0] n_bytes,
	output logic [3:0] seeds,
	output dakc_pkg::dakc_ecc_op_t last_op
);
	import dakc_pkg::*;
	logic [1:0] stall;
	logic [2:0] h_cnt;
	logic [3:0] e_cnt;
	logic [1:0] s_cnt;
	logic h_done;
	logic e_busy;
	logic e_done;
	logic e_fault;
	logic e_slow;
	// Outside a done pulse results are garbage, so stale answers are never reused
	assign sha_in = '{ready: stall != 2'h3, done: h_done, digest: h_done ? {8{32'hC0DE_F00D}} : '1};
	assign ecc_in = '{done: e_done, fault: e_done ? e_fault : 1'b1, pubkey: e_done ? PUB : ~PUB};
	// Hash: stalls every fourth cycle, records bytes, answers four cycles after last
	always_ff @(posedge aclk) begin
		stall <= stall + 2'h1;
		h_done <= (h_cnt == 3'h1);
		if (h_cnt != 3'h0)
			h_cnt <= h_cnt - 3'h1;
		if (sha_out.valid && sha_in.ready) begin
			msg[n_bytes[6:0]] <= sha_out.data;
			n_bytes <= n_bytes + 8'h01;
			if (sha_out.last)
				h_cnt <= 3'h4;
		end
		if (!aresetn || clr) begin
			stall <= 2'h0;
			n_bytes <= 8'h00;
			h_cnt <= 3'h0;
			h_done <= 1'b0;
		end
	end
	// Curve: one answer per request, alternating quick and slow
	always_ff @(posedge aclk) begin
		e_done <= 1'b0;
		if (e_busy && e_cnt == 4'h0) begin
			e_done <= 1'b1;
			e_busy <= 1'b0;
			e_fault <= fault_now;
		end else if (e_busy)
			e_cnt <= e_cnt - 4'h1;
		else if (ecc_out.req && !e_done) begin
			e_busy <= 1'b1;
			e_cnt <= e_slow ? 4'hC : 4'h1;
			e_slow <= !e_slow;
			last_op <= ecc_out.op;
		end
		if (!aresetn) begin
			e_busy <= 1'b0;
			e_slow <= 1'b0;
			e_done <= 1'b0;
		end
	end
	// Seed store: acknowledges after four cycles of request, counts updates
	always_ff @(posedge aclk) begin
		seed_ack <= 1'b0;
		s_cnt <= 2'h0;
		if (seed_req && !seed_ack)
			s_cnt <= s_cnt + 2'h1;
		if (s_cnt == 2'h3) begin
			seed_ack <= 1'b1;
			seeds <= seeds + 4'h1;
		end
		if (!aresetn) begin
			seed_ack <= 1'b0;
			seeds <= 4'h0;
			s_cnt <= 2'h0;
		end
	end
endmodule : dakc_engines
